// ### timer_match_irq_regs.sv
// Functional notes
// - Timer 2 A match sets bit 5
// - Timer 2 P match sets bit 4
// - Timer 2 bit 1 enables A interrupt
// - Timer 2 bit 0 enables P interrupt
// - Timer 0 P match sets bit 4
// - Timer 0 bit 1 enables A interrupt
// - Timer 0 bit 0 enables P interrupt
// - Timer 1 A match sets bit 5
// - Timer 1 P match sets bit 4
// - Timer 1 bit 1 enables A interrupt
// - Timer 1 bit 0 enables P interrupt
// - Bits 7-6 and 3-2 read zero
// - Flag requests interrupt only when enabled
// - Any set flag raises wake
`timescale 1ns/1ps
`default_nettype none
`include "timer_irq_defines.svh"

module timer_match_irq_regs #(
    parameter int NUM_TIMERS = `TIMER_COUNT
) (
    input wire logic aclk,
    input wire logic aresetn,
    // Write address channel
    input wire logic [`REG_ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // Write data channel
    input wire logic [`DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // Write response channel
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // Read address channel
    input wire logic [`REG_ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // Read data channel
    output logic [`DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Match events from the timers, one-cycle pulses on aclk, index is timer number
    input wire logic [NUM_TIMERS-1:0] cmpa_match,
    input wire logic [NUM_TIMERS-1:0] cmpp_match,
    // Per-timer vectored requests towards the interrupt controller
    output logic [NUM_TIMERS-1:0] match_irq_req,
    output logic wake_req,
    output logic irq
);

    match_bank_if #(.NUM_TIMERS(NUM_TIMERS)) bank_bus ();

    match_flag_bank #(
        .NUM_TIMERS(NUM_TIMERS)
    ) u_bank (
        .aclk(aclk),
        .aresetn(aresetn),
        .bus(bank_bus)
    );

    ////////////////////////////////////////////////////////////////////////
    // Write path

    timer_irq_pkg::bus_state_e wr_state_ff;
    timer_irq_pkg::bus_state_e nxt_wr_state;
    logic aw_held_ff;
    logic w_held_ff;
    logic nxt_aw_held;
    logic nxt_w_held;
    logic awready_ff;
    logic wready_ff;
    logic [`REG_ADDR_W-1:0] aw_addr_ff;
    logic [`DATA_W-1:0] w_data_ff;
    logic w_lane0_ff;
    logic [1:0] bresp_ff;
    logic [1:0] nxt_bresp;

    wire aw_take = s_axi_awvalid & awready_ff;
    wire w_take = s_axi_wvalid & wready_ff;
    wire wr_in_idle = (wr_state_ff == timer_irq_pkg::BUS_IDLE);
    wire do_write = wr_in_idle & aw_held_ff & w_held_ff;
    wire b_done = (wr_state_ff == timer_irq_pkg::BUS_RESP) & s_axi_bready;

    wire wsel_t0 = (aw_addr_ff == `OFF_TIMER0_IRQ);
    wire wsel_t1 = (aw_addr_ff == `OFF_TIMER1_IRQ);
    wire wsel_t2 = (aw_addr_ff == `OFF_TIMER2_IRQ);
    wire wsel_status = (aw_addr_ff == `OFF_EVT_STATUS);
    wire wsel_mask = (aw_addr_ff == `OFF_EVT_MASK);
    wire wsel_any = wsel_t0 | wsel_t1 | wsel_t2 | wsel_status | wsel_mask;

    // Only byte lane 0 carries register bits; other lanes are ignored
    wire wr_commit = do_write & w_lane0_ff;
    wire [7:0] wr_byte = w_data_ff[7:0];

    always_comb begin
        nxt_wr_state = wr_state_ff;
        nxt_bresp = bresp_ff;
        case (wr_state_ff)
            timer_irq_pkg::BUS_IDLE: begin
                if (do_write) begin
                    nxt_wr_state = timer_irq_pkg::BUS_RESP;
                    nxt_bresp = wsel_any ? `RESP_OKAY : `RESP_SLVERR;
                end
            end
            timer_irq_pkg::BUS_RESP: begin
                if (s_axi_bready) begin
                    nxt_wr_state = timer_irq_pkg::BUS_IDLE;
                end
            end
            default: begin
                nxt_wr_state = timer_irq_pkg::BUS_IDLE;
            end
        endcase
    end

    assign nxt_aw_held = do_write ? 1'b0 : (aw_held_ff | aw_take);
    assign nxt_w_held = do_write ? 1'b0 : (w_held_ff | w_take);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_state_ff <= timer_irq_pkg::BUS_IDLE;
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
            awready_ff <= 1'b0;
            wready_ff <= 1'b0;
            bresp_ff <= `RESP_OKAY;
        end else begin
            wr_state_ff <= nxt_wr_state;
            aw_held_ff <= nxt_aw_held;
            w_held_ff <= nxt_w_held;
            // Ready is offered only while the slot is empty and no response waits
            awready_ff <= ~nxt_aw_held & ~do_write & (nxt_wr_state == timer_irq_pkg::BUS_IDLE);
            wready_ff <= ~nxt_w_held & ~do_write & (nxt_wr_state == timer_irq_pkg::BUS_IDLE);
            bresp_ff <= nxt_bresp;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_addr_ff <= '0;
            w_data_ff <= '0;
            w_lane0_ff <= 1'b0;
        end else begin
            if (aw_take) begin
                aw_addr_ff <= s_axi_awaddr;
            end
            if (w_take) begin
                w_data_ff <= s_axi_wdata;
                w_lane0_ff <= s_axi_wstrb[0];
            end
        end
    end

    assign s_axi_awready = awready_ff;
    assign s_axi_wready = wready_ff;
    assign s_axi_bvalid = (wr_state_ff == timer_irq_pkg::BUS_RESP);
    assign s_axi_bresp = bresp_ff;

    ////////////////////////////////////////////////////////////////////////
    // Sub-register bank hookup

    assign bank_bus.wr_data = wr_byte;
    assign bank_bus.ev_a = cmpa_match;
    assign bank_bus.ev_p = cmpp_match;

    genvar t;
    generate
        for (t = 0; t < NUM_TIMERS; t++) begin : g_wr_sel
            wire sel_this = (t == 0) ? wsel_t0 : ((t == 1) ? wsel_t1 : wsel_t2);
            assign bank_bus.wr_en[t] = wr_commit & sel_this;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Event status (write one to clear) and mask

    logic [`EVT_W-1:0] evt_status_ff;
    logic [`EVT_W-1:0] evt_mask_ff;
    logic [`EVT_W-1:0] evt_pulse;
    logic [`EVT_W-1:0] nxt_evt_status;
    logic [`EVT_W-1:0] nxt_evt_mask;

    generate
        for (t = 0; t < NUM_TIMERS; t++) begin : g_evt
            assign evt_pulse[2*t] = cmpp_match[t];
            assign evt_pulse[2*t+1] = cmpa_match[t];
        end
    endgenerate

    wire [`EVT_W-1:0] status_clr = (wr_commit & wsel_status) ? wr_byte[`EVT_W-1:0] : '0;

    // A new event wins over a clear arriving in the same cycle
    assign nxt_evt_status = (evt_status_ff & ~status_clr) | evt_pulse;
    assign nxt_evt_mask = (wr_commit & wsel_mask) ? wr_byte[`EVT_W-1:0] : evt_mask_ff;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            evt_status_ff <= `EVT_RESET;
            evt_mask_ff <= `EVT_RESET;
        end else begin
            evt_status_ff <= nxt_evt_status;
            evt_mask_ff <= nxt_evt_mask;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read path

    timer_irq_pkg::bus_state_e rd_state_ff;
    timer_irq_pkg::bus_state_e nxt_rd_state;
    logic arready_ff;
    logic [`DATA_W-1:0] rdata_ff;
    logic [1:0] rresp_ff;
    timer_irq_pkg::subreg_t subreg_view [NUM_TIMERS];

    wire ar_take = s_axi_arvalid & arready_ff;

    generate
        for (t = 0; t < NUM_TIMERS; t++) begin : g_view
            always_comb begin
                subreg_view[t] = `SUBREG_RESET;
                subreg_view[t][`BIT_CMPA_FLAG] = bank_bus.flag_a[t];
                subreg_view[t][`BIT_CMPP_FLAG] = bank_bus.flag_p[t];
                subreg_view[t][`BIT_CMPA_EN] = bank_bus.en_a[t];
                subreg_view[t][`BIT_CMPP_EN] = bank_bus.en_p[t];
            end
        end
    endgenerate

    wire rsel_t0 = (s_axi_araddr == `OFF_TIMER0_IRQ);
    wire rsel_t1 = (s_axi_araddr == `OFF_TIMER1_IRQ);
    wire rsel_t2 = (s_axi_araddr == `OFF_TIMER2_IRQ);
    wire rsel_status = (s_axi_araddr == `OFF_EVT_STATUS);
    wire rsel_mask = (s_axi_araddr == `OFF_EVT_MASK);
    wire rsel_any = rsel_t0 | rsel_t1 | rsel_t2 | rsel_status | rsel_mask;

    wire [7:0] rd_byte =
        rsel_t0 ? subreg_view[0] :
        rsel_t1 ? subreg_view[1] :
        rsel_t2 ? subreg_view[2] :
        rsel_status ? {2'h0, evt_status_ff} :
        rsel_mask ? {2'h0, evt_mask_ff} : 8'h00;

    always_comb begin
        nxt_rd_state = rd_state_ff;
        case (rd_state_ff)
            timer_irq_pkg::BUS_IDLE: begin
                if (ar_take) begin
                    nxt_rd_state = timer_irq_pkg::BUS_RESP;
                end
            end
            timer_irq_pkg::BUS_RESP: begin
                if (s_axi_rready) begin
                    nxt_rd_state = timer_irq_pkg::BUS_IDLE;
                end
            end
            default: begin
                nxt_rd_state = timer_irq_pkg::BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_state_ff <= timer_irq_pkg::BUS_IDLE;
            arready_ff <= 1'b0;
            rdata_ff <= '0;
            rresp_ff <= `RESP_OKAY;
        end else begin
            rd_state_ff <= nxt_rd_state;
            arready_ff <= ~ar_take & (nxt_rd_state == timer_irq_pkg::BUS_IDLE);
            if (ar_take) begin
                rdata_ff <= {24'h000000, rd_byte};
                rresp_ff <= rsel_any ? `RESP_OKAY : `RESP_SLVERR;
            end
        end
    end

    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid = (rd_state_ff == timer_irq_pkg::BUS_RESP);
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;

    ////////////////////////////////////////////////////////////////////////
    // Requests, wake and interrupt line

    logic [NUM_TIMERS-1:0] match_irq_req_ff;
    logic wake_req_ff;
    logic irq_ff;

    // A disabled flag stays pending but asks for no vectored request
    wire [NUM_TIMERS-1:0] nxt_req = (bank_bus.flag_a & bank_bus.en_a) |
        (bank_bus.flag_p & bank_bus.en_p);
    // Wake ignores enables so a pending match always ends sleep
    wire nxt_wake = |(bank_bus.flag_a | bank_bus.flag_p);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            match_irq_req_ff <= '0;
            wake_req_ff <= 1'b0;
            irq_ff <= 1'b0;
        end else begin
            match_irq_req_ff <= nxt_req;
            wake_req_ff <= nxt_wake;
            irq_ff <= |(evt_status_ff & evt_mask_ff);
        end
    end

    assign match_irq_req = match_irq_req_ff;
    assign wake_req = wake_req_ff;
    assign irq = irq_ff;

    // Protection bits carry no meaning here
    wire unused_prot = ^{s_axi_awprot, s_axi_arprot, w_data_ff[`DATA_W-1:8]};

endmodule

`default_nettype wire

// ### timer_irq_defines.svh
`ifndef TIMER_IRQ_DEFINES_SVH
`define TIMER_IRQ_DEFINES_SVH

// Register byte offsets on the bus
`define REG_ADDR_W 8
`define OFF_TIMER2_IRQ 8'h00
`define OFF_TIMER0_IRQ 8'h04
`define OFF_TIMER1_IRQ 8'h08
`define OFF_EVT_STATUS 8'h0c
`define OFF_EVT_MASK 8'h10

// Sub-register layout
`define SUBREG_W 8
`define BIT_CMPA_FLAG 5
`define BIT_CMPP_FLAG 4
`define BIT_CMPA_EN 1
`define BIT_CMPP_EN 0
`define SUBREG_RESET 8'h00

// Event status and mask layout: bit 2k is timer k P match, bit 2k+1 its A match
`define EVT_W 6
`define EVT_RESET 6'h00

// Bus constants
`define DATA_W 32
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define TIMER_COUNT 3

`endif

// ### timer_irq_pkg.sv
`default_nettype none

package timer_irq_pkg;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'h1,
        BUS_RESP = 2'h2
    } bus_state_e;

    typedef logic [7:0] subreg_t;

endpackage

`default_nettype wire

// ### match_bank_if.sv
`timescale 1ns/1ps
`default_nettype none

interface match_bank_if #(
    parameter int NUM_TIMERS = 3
);
    logic [NUM_TIMERS-1:0] wr_en;
    logic [7:0] wr_data;
    logic [NUM_TIMERS-1:0] ev_a;
    logic [NUM_TIMERS-1:0] ev_p;
    logic [NUM_TIMERS-1:0] flag_a;
    logic [NUM_TIMERS-1:0] flag_p;
    logic [NUM_TIMERS-1:0] en_a;
    logic [NUM_TIMERS-1:0] en_p;

    modport ctrl (
        output wr_en,
        output wr_data,
        output ev_a,
        output ev_p,
        input flag_a,
        input flag_p,
        input en_a,
        input en_p
    );

    modport bank (
        input wr_en,
        input wr_data,
        input ev_a,
        input ev_p,
        output flag_a,
        output flag_p,
        output en_a,
        output en_p
    );
endinterface

`default_nettype wire

// ### match_flag_bank.sv
`timescale 1ns/1ps
`default_nettype none
`include "timer_irq_defines.svh"

module match_flag_bank #(
    parameter int NUM_TIMERS = 3
) (
    input wire logic aclk,
    input wire logic aresetn,
    match_bank_if.bank bus
);

    logic [NUM_TIMERS-1:0] flag_a_ff;
    logic [NUM_TIMERS-1:0] flag_p_ff;
    logic [NUM_TIMERS-1:0] en_a_ff;
    logic [NUM_TIMERS-1:0] en_p_ff;

    ////////////////////////////////////////////////////////////////////////
    genvar k;
    generate
        for (k = 0; k < NUM_TIMERS; k++) begin : g_timer
            logic nxt_flag_a;
            logic nxt_flag_p;
            logic nxt_en_a;
            logic nxt_en_p;

            // A match in the cycle of a software clear still sets the flag
            assign nxt_flag_a = bus.ev_a[k] |
                (bus.wr_en[k] ? bus.wr_data[`BIT_CMPA_FLAG] : flag_a_ff[k]);
            assign nxt_flag_p = bus.ev_p[k] |
                (bus.wr_en[k] ? bus.wr_data[`BIT_CMPP_FLAG] : flag_p_ff[k]);
            assign nxt_en_a = bus.wr_en[k] ? bus.wr_data[`BIT_CMPA_EN] : en_a_ff[k];
            assign nxt_en_p = bus.wr_en[k] ? bus.wr_data[`BIT_CMPP_EN] : en_p_ff[k];

            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    flag_a_ff[k] <= 1'b0;
                    flag_p_ff[k] <= 1'b0;
                    en_a_ff[k] <= 1'b0;
                    en_p_ff[k] <= 1'b0;
                end else begin
                    flag_a_ff[k] <= nxt_flag_a;
                    flag_p_ff[k] <= nxt_flag_p;
                    en_a_ff[k] <= nxt_en_a;
                    en_p_ff[k] <= nxt_en_p;
                end
            end
        end
    endgenerate

    assign bus.flag_a = flag_a_ff;
    assign bus.flag_p = flag_p_ff;
    assign bus.en_a = en_a_ff;
    assign bus.en_p = en_p_ff;

endmodule

`default_nettype wire

// ### timer_match_irq_checker.sv
`timescale 1ns/1ps
`default_nettype none
`include "timer_irq_defines.svh"

module timer_match_irq_checker #(
    parameter int NUM_TIMERS = 3
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [`DATA_W-1:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [NUM_TIMERS-1:0] cmpa_match,
    input wire logic [NUM_TIMERS-1:0] cmpp_match,
    input wire logic [NUM_TIMERS-1:0] match_irq_req,
    input wire logic wake_req,
    input wire logic irq
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    wire any_match = |{cmpa_match, cmpp_match};

    chk_wake_follows: assert property (any_match |-> ##2 wake_req)
        else $error("wake request missing after a match event");
    chk_irq_cause: assert property ($rose(irq) |-> $past(s_axi_bvalid)
        || $past(any_match, 2))
        else $error("interrupt rose without an event or register write");
    chk_req_wake: assert property (|match_irq_req |-> wake_req)
        else $error("vectored request without any flag set");
    chk_aw_block: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
        else $error("write address accepted twice");
    chk_b_hold: assert property ($fell(s_axi_bvalid) |-> $past(s_axi_bready))
        else $error("write response dropped before acceptance");
    chk_r_hold: assert property ($fell(s_axi_rvalid) |-> $past(s_axi_rready))
        else $error("read data dropped before acceptance");
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    chk_rdata_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:6] == 26'h0)
        else $error("unimplemented read bits not zero");
endmodule

bind timer_match_irq_regs timer_match_irq_checker #(.NUM_TIMERS(NUM_TIMERS)) u_checker (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .cmpa_match(cmpa_match),
    .cmpp_match(cmpp_match), .match_irq_req(match_irq_req), .wake_req(wake_req), .irq(irq)
);

`default_nettype wire

// ### timer_match_irq_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "timer_irq_defines.svh"

module timer_match_irq_regs_bench;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic awvalid = 1'h0;
    logic wvalid = 1'h0;
    logic bready = 1'h0;
    logic arvalid = 1'h0;
    logic rready = 1'h0;
    logic [2:0] cmpa = 3'h0;
    logic [2:0] cmpp = 3'h0;
    logic awready, wready, bvalid, arready, rvalid, wake_req, irq;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [2:0] irq_req;
    logic [7:0] off, fb, eb, sb;
    int fail_count = 0;
    int check_count = 0;
    int k, t;

    always #20 aclk = ~aclk;

    timer_match_irq_regs u_dut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .cmpa_match(cmpa), .cmpp_match(cmpp),
        .match_irq_req(irq_req), .wake_req(wake_req), .irq(irq)
    );

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict;
        $display("counts: %0d checks, %0d mismatches", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Address and data go out together; each drops on its own handshake
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic [1:0] er);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        // Only the watchdog ends a wait that never gets its answer
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
        end while (!bvalid);
        bready <= 1'h0;
        check({30'h0, bresp}, {30'h0, er});
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'h0;
        end while (!rvalid);
        rready <= 1'h0;
        check(rdata, ed);
        check({30'h0, rresp}, {30'h0, er});
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'h1;
        for (k = 0; k < 5; k++) rd(8'(k * 4), 32'h0, `RESP_OKAY);
        rd(8'h14, 32'h0, `RESP_SLVERR);
        wr(8'h14, 32'hff, 4'h1, `RESP_SLVERR);
        for (k = 0; k < 3; k++) begin
            wr(8'(k * 4), 32'hff, 4'h1, `RESP_OKAY);
            rd(8'(k * 4), 32'h33, `RESP_OKAY);
            wr(8'(k * 4), 32'h0, 4'h0, `RESP_OKAY);
            rd(8'(k * 4), 32'h33, `RESP_OKAY);
            wr(8'(k * 4), 32'h0, 4'h1, `RESP_OKAY);
        end
        $display("test registers done");
        for (k = 0; k < 3; k++) begin
            for (t = 0; t < 2; t++) begin
                off = (k == 2) ? 8'h00 : 8'(k * 4 + 4);
                fb = t ? 8'h20 : 8'h10;
                eb = t ? 8'h02 : 8'h01;
                sb = 8'h01 << (2 * k + t);
                @(posedge aclk);
                cmpa <= t ? 3'(1 << k) : 3'h0;
                cmpp <= t ? 3'h0 : 3'(1 << k);
                @(posedge aclk);
                cmpa <= 3'h0;
                cmpp <= 3'h0;
                @(posedge aclk);
                #1;
                check({31'h0, wake_req}, 32'h1);
                check({29'h0, irq_req}, 32'h0);
                check({31'h0, irq}, 32'h0);
                rd(off, {24'h0, fb}, `RESP_OKAY);
                rd(8'h0c, {24'h0, sb}, `RESP_OKAY);
                wr(off, {24'h0, fb | eb}, 4'h1, `RESP_OKAY);
                @(posedge aclk);
                #1;
                check({29'h0, irq_req}, 32'(1 << k));
                wr(8'h10, {24'h0, sb}, 4'h1, `RESP_OKAY);
                @(posedge aclk);
                #1;
                check({31'h0, irq}, 32'h1);
                wr(8'h0c, {24'h0, sb}, 4'h1, `RESP_OKAY);
                rd(8'h0c, 32'h0, `RESP_OKAY);
                check({31'h0, irq}, 32'h0);
                wr(off, 32'h0, 4'h1, `RESP_OKAY);
                @(posedge aclk);
                #1;
                check({31'h0, wake_req}, 32'h0);
                check({29'h0, irq_req}, 32'h0);
            end
        end
        $display("test events done");
        // Reset in mid-run must clear bits that software has set
        wr(8'h00, 32'hff, 4'h1, `RESP_OKAY);
        @(posedge aclk);
        aresetn <= 1'h0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'h1;
        rd(8'h00, 32'h0, `RESP_OKAY);
        check({30'h0, wake_req, irq}, 32'h0);
        check({29'h0, irq_req}, 32'h0);
        $display("test reset done");
        give_verdict();
    end

    // Tests need about 280 cycles; over fifty times that covers slow answers
    initial begin
        repeat (15000) @(posedge aclk);
        fail_count++;
        give_verdict();
    end
endmodule

`default_nettype wire
